//--- cfg_decoder_pkg.sv
// Package with register addresses, field positions, lengths and carrier types for the command decoder.
package cfg_decoder_pkg;

    // ==========================================================
    // Register addresses
    // ==========================================================
    localparam logic [7:0] ADDR_RESET_CONTROL      = 8'h01;
    localparam logic [7:0] ADDR_ACTIVITY_LED       = 8'h02;
    localparam logic [7:0] ADDR_POWER_DOWN         = 8'h05;
    localparam logic [7:0] ADDR_OUTPUT_FREQUENCY   = 8'h10;
    localparam logic [7:0] ADDR_OUTPUT_LEVEL       = 8'h11;
    localparam logic [7:0] ADDR_TUNING_MODE        = 8'h12;
    localparam logic [7:0] ADDR_LEVEL_LOOP_MODE    = 8'h13;
    localparam logic [7:0] ADDR_LEVEL_DAC_OVERRIDE = 8'h14;
    localparam logic [7:0] ADDR_REF_CLOCK_CONTROL  = 8'h15;
    localparam logic [7:0] ADDR_REF_TRIM_DAC       = 8'h16;
    localparam logic [7:0] ADDR_USER_NVM_WRITE     = 8'h23;
    localparam logic [7:0] ADDR_OUTPUT_ENABLE      = 8'h26;
    localparam logic [7:0] ADDR_SAVE_POWER_ON      = 8'h28;
    localparam logic [7:0] ADDR_LEVEL_TRACKING_DIS = 8'h29;

    // ==========================================================
    // Data byte counts per register
    // ==========================================================
    localparam logic [2:0] LEN_BYTE1 = 3'h1;
    localparam logic [2:0] LEN_WORD2 = 3'h2;
    localparam logic [2:0] LEN_WORD3 = 3'h3;
    localparam logic [2:0] LEN_WORD5 = 3'h5;
    localparam logic [2:0] LEN_NONE  = 3'h0;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int LEVEL_SIGN_BIT     = 15;
    localparam int LEVEL_MAG_MSB      = 14;
    localparam int TUNE_FAST_BIT      = 2;
    localparam int TUNE_STEP_MSB      = 1;
    localparam int REF_HIGH_RATE_BIT  = 2;
    localparam int REF_OUT_EN_BIT     = 1;
    localparam int REF_EXT_LOCK_BIT   = 0;
    localparam int NVM_DATA_MSB       = 7;
    localparam int NVM_ADDR_LSB       = 8;
    localparam int NVM_ADDR_MSB       = 23;
    localparam int DAC_WORD_MSB       = 13;

    // ==========================================================
    // Reset values of the configuration state
    // ==========================================================
    localparam logic [39:0] RST_FREQUENCY = 40'h0000000000;
    localparam logic [15:0] RST_LEVEL     = 16'h0000;
    localparam logic [2:0]  RST_TUNING    = 3'h0;
    localparam logic        RST_OUT_EN    = 1'b1;

    // Tuning step encodings.
    localparam logic [1:0] STEP_COARSE = 2'h0;
    localparam logic [1:0] STEP_MEDIUM = 2'h1;
    localparam logic [1:0] STEP_FINE   = 2'h2;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic [39:0] frequency;
        logic        level_negative;
        logic [14:0] level_magnitude;
        logic        fast_tune;
        logic [1:0]  tune_step;
        logic        level_loop_open;
        logic [13:0] level_dac;
        logic        high_rate_ref_select;
        logic        ref_out_enable;
        logic        ext_ref_lock;
        logic [13:0] ref_trim_dac;
        logic        output_enable;
        logic        power_down;
        logic        activity_led;
        logic        level_tracking_off;
    } config_state_t;

    typedef struct packed {
        logic        reset_pulse;
        logic        reset_keep_state;
        logic        save_pulse;
        logic        nvm_write_pulse;
        logic [15:0] nvm_addr;
        logic [7:0]  nvm_data;
        logic        frequency_pulse;
        logic        level_pulse;
    } config_event_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [39:0] data;
    } frame_t;

endpackage

//--- frame_assembler.sv
// Frame assembler: takes an address byte then MSB-first data bytes and emits one whole frame.
`timescale 1ns/1ps
`default_nettype none

module frame_assembler
(
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     byte_valid,
    input  wire logic [7:0]               byte_data,
    input  wire logic                     frame_start,
    output var  cfg_decoder_pkg::frame_t  frame,
    output logic                          unknown_addr
);

    typedef enum {IDLE, DATA} asm_state_t;

    asm_state_t  state_q;
    logic [7:0]  addr_q;
    logic [39:0] shift_q;
    logic [2:0]  left_q;

    // ==========================================================
    // Length decode
    // ==========================================================
    // Every link hands the same byte stream here, so one map serves all.
    function automatic logic [2:0] data_len(input logic [7:0] a);
        case (a)
            cfg_decoder_pkg::ADDR_OUTPUT_FREQUENCY:   data_len = cfg_decoder_pkg::LEN_WORD5;
            cfg_decoder_pkg::ADDR_OUTPUT_LEVEL,
            cfg_decoder_pkg::ADDR_LEVEL_DAC_OVERRIDE,
            cfg_decoder_pkg::ADDR_REF_TRIM_DAC:       data_len = cfg_decoder_pkg::LEN_WORD2;
            cfg_decoder_pkg::ADDR_USER_NVM_WRITE:     data_len = cfg_decoder_pkg::LEN_WORD3;
            cfg_decoder_pkg::ADDR_RESET_CONTROL,
            cfg_decoder_pkg::ADDR_ACTIVITY_LED,
            cfg_decoder_pkg::ADDR_POWER_DOWN,
            cfg_decoder_pkg::ADDR_TUNING_MODE,
            cfg_decoder_pkg::ADDR_LEVEL_LOOP_MODE,
            cfg_decoder_pkg::ADDR_REF_CLOCK_CONTROL,
            cfg_decoder_pkg::ADDR_OUTPUT_ENABLE,
            cfg_decoder_pkg::ADDR_SAVE_POWER_ON,
            cfg_decoder_pkg::ADDR_LEVEL_TRACKING_DIS: data_len = cfg_decoder_pkg::LEN_BYTE1;
            default:                                  data_len = cfg_decoder_pkg::LEN_NONE;
        endcase
    endfunction

    wire logic [2:0]  new_len   = data_len(byte_data);
    wire logic        take_addr = byte_valid && (state_q == IDLE || frame_start);
    wire logic        take_data = byte_valid && state_q == DATA && !frame_start;
    wire logic [39:0] shifted   = {shift_q[31:0], byte_data};
    wire logic        last_byte = take_data && left_q == 3'h1;

    // ==========================================================
    // Byte sequencing
    // ==========================================================
    // Data shifts in from the bottom, so the first byte ends on top.
    // A frame_start pulse abandons a short frame rather than merging two.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q      <= IDLE;
            addr_q       <= 8'h00;
            shift_q      <= 40'h0000000000;
            left_q       <= 3'h0;
            frame        <= '0;
            unknown_addr <= 1'b0;
        end
        else
        begin
            frame.valid  <= last_byte;
            unknown_addr <= take_addr && new_len == cfg_decoder_pkg::LEN_NONE;
            if (take_addr)
            begin
                addr_q  <= byte_data;
                left_q  <= new_len;
                shift_q <= 40'h0000000000;
                state_q <= (new_len == cfg_decoder_pkg::LEN_NONE) ? IDLE : DATA;
            end
            else if (take_data)
            begin
                shift_q <= shifted;
                left_q  <= left_q - 3'h1;
                if (last_byte)
                begin
                    frame.addr <= addr_q;
                    frame.data <= shifted;
                    state_q    <= IDLE;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- rf_source_config_command_decoder.sv
// Configuration command decoder for an RF signal source: byte stream in, configuration state out.
`timescale 1ns/1ps
`default_nettype none

module rf_source_config_command_decoder
(
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic                            byte_valid,
    input  wire logic [7:0]                      byte_data,
    input  wire logic                            frame_start,
    output var  cfg_decoder_pkg::config_state_t  config_state,
    output var  cfg_decoder_pkg::config_event_t  config_event,
    output logic                                 unknown_addr
);

    cfg_decoder_pkg::frame_t frame;
    logic                    unknown_int;
    logic                    valid_q;
    logic [7:0]              byte_q;
    logic                    start_q;

    // ==========================================================
    // Input staging
    // ==========================================================
    // The link front end sits on this clock, so one register stage only eases timing.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            valid_q <= 1'b0;
            byte_q  <= 8'h00;
            start_q <= 1'b0;
        end
        else
        begin
            valid_q <= byte_valid;
            byte_q  <= byte_data;
            start_q <= frame_start;
        end
    end

    // Same assembler whatever link delivered the bytes.
    frame_assembler frame_assembler_i
    (
        .clk          (clk),
        .rst_b        (rst_b),
        .byte_valid   (valid_q),
        .byte_data    (byte_q),
        .frame_start  (start_q),
        .frame        (frame),
        .unknown_addr (unknown_int)
    );

    // ==========================================================
    // Address decode
    // ==========================================================
    // The byte count is fixed per register, so a short host frame takes the following bytes as data unless frame_start abandons it.
    wire logic hit_reset  = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_RESET_CONTROL;
    wire logic hit_led    = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_ACTIVITY_LED;
    wire logic hit_pdown  = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_POWER_DOWN;
    wire logic hit_freq   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_OUTPUT_FREQUENCY;
    wire logic hit_level  = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_OUTPUT_LEVEL;
    wire logic hit_tune   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_TUNING_MODE;
    wire logic hit_loop   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_LEVEL_LOOP_MODE;
    wire logic hit_ldac   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_LEVEL_DAC_OVERRIDE;
    wire logic hit_ref    = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_REF_CLOCK_CONTROL;
    wire logic hit_trim   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_REF_TRIM_DAC;
    wire logic hit_nvm    = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_USER_NVM_WRITE;
    wire logic hit_outen  = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_OUTPUT_ENABLE;
    wire logic hit_save   = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_SAVE_POWER_ON;
    wire logic hit_track  = frame.valid && frame.addr == cfg_decoder_pkg::ADDR_LEVEL_TRACKING_DIS;
    wire logic [7:0] lsb  = frame.data[7:0];
    wire logic [15:0] w16 = frame.data[15:0];

    // ==========================================================
    // Configuration state
    // ==========================================================
    // Write-only state: there is no read path at all, status leaves by other means.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_state                 <= '0;
            config_state.frequency       <= cfg_decoder_pkg::RST_FREQUENCY;
            config_state.output_enable   <= cfg_decoder_pkg::RST_OUT_EN;
            {config_state.fast_tune, config_state.tune_step} <= cfg_decoder_pkg::RST_TUNING;
        end
        else
        begin
            if (hit_freq)
                config_state.frequency <= frame.data;
            if (hit_level)
            begin
                config_state.level_negative  <= w16[cfg_decoder_pkg::LEVEL_SIGN_BIT];
                config_state.level_magnitude <= w16[cfg_decoder_pkg::LEVEL_MAG_MSB:0];
            end
            if (hit_tune)
            begin
                config_state.fast_tune <= lsb[cfg_decoder_pkg::TUNE_FAST_BIT];
                config_state.tune_step <= lsb[cfg_decoder_pkg::TUNE_STEP_MSB:0];
            end
            if (hit_ref)
            begin
                config_state.high_rate_ref_select <= lsb[cfg_decoder_pkg::REF_HIGH_RATE_BIT];
                config_state.ref_out_enable       <= lsb[cfg_decoder_pkg::REF_OUT_EN_BIT];
                config_state.ext_ref_lock         <= lsb[cfg_decoder_pkg::REF_EXT_LOCK_BIT];
            end
            if (hit_ldac)
                config_state.level_dac <= w16[cfg_decoder_pkg::DAC_WORD_MSB:0];
            if (hit_trim)
                config_state.ref_trim_dac <= w16[cfg_decoder_pkg::DAC_WORD_MSB:0];
            // Single-bit controls look at bit 0 only.
            if (hit_loop)
                config_state.level_loop_open <= lsb[0];
            if (hit_outen)
                config_state.output_enable <= lsb[0];
            if (hit_pdown)
                config_state.power_down <= lsb[0];
            if (hit_led)
                config_state.activity_led <= lsb[0];
            if (hit_track)
                config_state.level_tracking_off <= lsb[0];
        end
    end

    // ==========================================================
    // One-cycle command events
    // ==========================================================
    // Actions that the rest of the device carries out leave as pulses with their operands held.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_event <= '0;
            unknown_addr <= 1'b0;
        end
        else
        begin
            unknown_addr                  <= unknown_int;
            config_event.reset_pulse      <= hit_reset;
            config_event.save_pulse       <= hit_save;
            config_event.nvm_write_pulse  <= hit_nvm;
            config_event.frequency_pulse  <= hit_freq;
            config_event.level_pulse      <= hit_level;
            if (hit_reset)
                config_event.reset_keep_state <= lsb[0];
            if (hit_nvm)
            begin
                config_event.nvm_addr <= frame.data[cfg_decoder_pkg::NVM_ADDR_MSB:cfg_decoder_pkg::NVM_ADDR_LSB];
                config_event.nvm_data <= frame.data[cfg_decoder_pkg::NVM_DATA_MSB:0];
            end
        end
    end

endmodule

`default_nettype wire

//--- cfg_host_model.sv
// Host driver model that streams configuration frames into the decoder.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host byte source
// ==========================================================
module cfg_host_model
(
    input  wire logic       clk,
    output var  logic       byte_valid,
    output var  logic [7:0] byte_data,
    output var  logic       frame_start
);
    // Lines start idle with a data pattern that is not a register address.
    initial
    begin
        byte_valid  = 1'b0;
        byte_data   = 8'hA5;
        frame_start = 1'b0;
    end

    // Address byte first, then only n data bytes, most significant first.
    // Idle data shows the inverse of the last byte, so a stale byte is never mistaken for a fresh one.
    task automatic send(input logic [7:0] addr, input logic [39:0] data, input int n, input logic fs);
        @(negedge clk);
        byte_valid  = 1'b1;
        byte_data   = addr;
        frame_start = fs;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clk);
            frame_start = 1'b0;
            byte_data   = data[8*i +: 8];
        end
        @(negedge clk);
        byte_valid  = 1'b0;
        frame_start = 1'b0;
        byte_data   = ~byte_data;
    endtask
endmodule
`default_nettype wire

//--- rf_source_config_command_decoder_properties.sv
// Port checker for the configuration command decoder.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
// ==========================================================
module rf_source_config_command_decoder_checker
(
    input wire logic                           clk,
    input wire logic                           rst_b,
    input wire logic                           byte_valid,
    input wire logic [7:0]                     byte_data,
    input wire logic                           frame_start,
    input wire cfg_decoder_pkg::config_state_t config_state,
    input wire cfg_decoder_pkg::config_event_t config_event,
    input wire logic                           unknown_addr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Input stage, assembler and output register put results three samples after the byte that causes them.
    // Without such a byte nothing moves.
    a_state_quiet: assert property (!$past(byte_valid, 3) |-> $stable(config_state))
        else $error("state changed without a byte");
    a_unknown_cause: assert property (unknown_addr |-> $past(byte_valid, 3))
        else $error("unknown address flag without a byte");
    a_level_fields: assert property (config_event.level_pulse && $past(byte_valid, 4)
        |-> {config_state.level_negative, config_state.level_magnitude} == {$past(byte_data, 4), $past(byte_data, 3)})
        else $error("level bytes misplaced");
    a_freq_order: assert property (config_event.frequency_pulse && $past(byte_valid, 7) && $past(byte_valid, 6)
        && $past(byte_valid, 5) && $past(byte_valid, 4) |-> config_state.frequency == {$past(byte_data, 7),
        $past(byte_data, 6), $past(byte_data, 5), $past(byte_data, 4), $past(byte_data, 3)})
        else $error("frequency bytes misplaced");
    a_nvm_fields: assert property (config_event.nvm_write_pulse && $past(byte_valid, 5) && $past(byte_valid, 4)
        |-> {config_event.nvm_addr, config_event.nvm_data}
        == {$past(byte_data, 5), $past(byte_data, 4), $past(byte_data, 3)})
        else $error("memory write fields misplaced");
    a_tune_fields: assert property ($changed({config_state.fast_tune, config_state.tune_step})
        |-> {config_state.fast_tune, config_state.tune_step} == $past(byte_data[2:0], 3))
        else $error("tuning fields misplaced");
    a_single_bit: assert property ($changed(config_state.output_enable)
        |-> $past(byte_valid, 3) && $past(byte_data[0], 3) == config_state.output_enable)
        else $error("output enable not from bit 0");
    a_event_quiet: assert property (!$past(byte_valid, 3)
        |-> !config_event.save_pulse && !config_event.reset_pulse && $stable(config_event.nvm_addr))
        else $error("event without a byte");
    a_pulse_single: assert property ((config_event.level_pulse || config_event.frequency_pulse)
        |=> !(config_event.level_pulse || config_event.frequency_pulse))
        else $error("write pulse longer than one cycle");

    c_level: cover property (config_event.level_pulse);
    c_nvm: cover property (config_event.nvm_write_pulse);
    c_unknown: cover property (unknown_addr);
    c_resync_level: cover property (config_event.level_pulse && $past(frame_start, 5));
endmodule

bind rf_source_config_command_decoder rf_source_config_command_decoder_checker
    rf_source_config_command_decoder_checker_i (.clk(clk), .rst_b(rst_b), .byte_valid(byte_valid),
    .byte_data(byte_data), .frame_start(frame_start), .config_state(config_state),
    .config_event(config_event), .unknown_addr(unknown_addr));
`default_nettype wire

//--- rf_source_config_command_decoder_test.sv
// Self-checking testbench for the configuration command decoder.
`timescale 1ns/1ps
`default_nettype none

module rf_source_config_command_decoder_test;
    logic                           clk;
    logic                           rst_b;
    logic                           byte_valid;
    logic [7:0]                     byte_data;
    logic                           frame_start;
    cfg_decoder_pkg::config_state_t config_state;
    cfg_decoder_pkg::config_event_t config_event;
    logic                           unknown_addr;
    cfg_decoder_pkg::config_state_t exp;
    logic [7:0]                     pulse_n [0:5];
    logic [7:0]                     ctl_addr [0:4] = '{8'h05, 8'h02, 8'h29, 8'h13, 8'h26};
    int                             mismatches = 0;
    int                             cmp_count = 0;

    // ==========================================================
    // Clock, design and host
    // ==========================================================
    initial clk = 1'b0;
    always #2 clk = ~clk;

    rf_source_config_command_decoder rf_source_config_command_decoder_i (.clk(clk), .rst_b(rst_b),
        .byte_valid(byte_valid), .byte_data(byte_data), .frame_start(frame_start),
        .config_state(config_state), .config_event(config_event), .unknown_addr(unknown_addr));
    cfg_host_model cfg_host_model_i (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data),
        .frame_start(frame_start));

    // Pulses are counted, so a missing or doubled pulse shows in the totals.
    always @(posedge clk)
    begin
        pulse_n[0] <= pulse_n[0] + config_event.level_pulse;
        pulse_n[1] <= pulse_n[1] + config_event.frequency_pulse;
        pulse_n[2] <= pulse_n[2] + config_event.nvm_write_pulse;
        pulse_n[3] <= pulse_n[3] + config_event.save_pulse;
        pulse_n[4] <= pulse_n[4] + config_event.reset_pulse;
        pulse_n[5] <= pulse_n[5] + unknown_addr;
    end

    // ==========================================================
    // Checks and access tasks
    // ==========================================================
    task automatic check_state();
        cmp_count++;
        if (config_state !== exp)
        begin
            mismatches++;
            $display("ERROR config_state expected %h seen %h", exp, config_state);
        end
    endtask

    task automatic check_value(input string what, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    // Five falling edges cover the fixed three-edge answer latency with margin.
    task automatic wr(input logic [7:0] addr, input logic [39:0] data, input int n);
        cfg_host_model_i.send(addr, data, n, 1'b0);
        repeat (5) @(negedge clk);
        check_state();
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #(4 * 5000);
        mismatches++;
        results();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        exp = '0;
        exp.output_enable = 1'b1;
        pulse_n = '{default: 8'h00};
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        check_state();
        {exp.level_negative, exp.level_magnitude} = 16'h83ED;
        wr(8'h11, 40'h83ED, 2);
        {exp.level_negative, exp.level_magnitude} = 16'h7FFF;
        wr(8'h11, 40'h7FFF, 2);
        exp.frequency = 40'h123456789A;
        wr(8'h10, 40'h123456789A, 5);
        for (int k = 0; k < 3; k++)
        begin
            {exp.fast_tune, exp.tune_step} = {k != 1, k[1:0]};
            wr(8'h12, {37'h0, exp.fast_tune, exp.tune_step}, 1);
        end
        {exp.high_rate_ref_select, exp.ref_out_enable, exp.ext_ref_lock} = 3'h7;
        wr(8'h15, 40'h0F, 1);
        {exp.high_rate_ref_select, exp.ref_out_enable, exp.ext_ref_lock} = 3'h2;
        wr(8'h15, 40'h02, 1);
        exp.level_dac = 14'h3ABC;
        wr(8'h14, 40'h3ABC, 2);
        exp.ref_trim_dac = 14'h1234;
        wr(8'h16, 40'h1234, 2);
        for (int p = 0; p < 2; p++)
            for (int j = 0; j < 5; j++)
            begin
                case (j)
                    0: exp.power_down = (p == 0);
                    1: exp.activity_led = (p == 0);
                    2: exp.level_tracking_off = (p == 0);
                    3: exp.level_loop_open = (p == 0);
                    default: exp.output_enable = (p == 0);
                endcase
                wr(ctl_addr[j], {32'h0, 7'h7F, p == 0}, 1);
            end
        wr(8'h01, 40'h01, 1);
        check_value("reset_keep_state", 16'h0001, {15'h0, config_event.reset_keep_state});
        wr(8'h28, 40'hA5, 1);
        wr(8'h23, 40'h1F0022, 3);
        check_value("nvm_addr", 16'h1F00, config_event.nvm_addr);
        check_value("nvm_data", 16'h0022, {8'h00, config_event.nvm_data});
        wr(8'h17, 40'h0, 0);
        cfg_host_model_i.send(8'h10, 40'hFFFF, 2, 1'b0);
        {exp.level_negative, exp.level_magnitude} = 16'h0123;
        cfg_host_model_i.send(8'h11, 40'h0123, 2, 1'b1);
        repeat (5) @(negedge clk);
        check_state();
        check_value("level_pulse", 16'h0003, {8'h00, pulse_n[0]});
        check_value("frequency_pulse", 16'h0001, {8'h00, pulse_n[1]});
        check_value("nvm_write_pulse", 16'h0001, {8'h00, pulse_n[2]});
        check_value("save_pulse", 16'h0001, {8'h00, pulse_n[3]});
        check_value("reset_pulse", 16'h0001, {8'h00, pulse_n[4]});
        check_value("unknown_addr", 16'h0001, {8'h00, pulse_n[5]});
        results();
    end
endmodule
`default_nettype wire
